// >>> logic/vpf_top.sv
// vector packet formatter: packs decoded vector words, shifts them to the host
// assumes the decoder runs on CLOCK; link clock and select come from the host pins
`timescale 1ns/1ps
`default_nettype none

module vpf_top
	import vpf_pkg::*;
(
	// clock and reset
	input  wire logic        CLOCK,
	input  wire logic        SYS_RST,
	// decoded vector words
	input  wire logic        VEC_VALID,
	input  wire vpf_vec_s    VEC_IN,
	output logic             VEC_READY,
	// register port
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	output logic      [31:0] REG_RDATA,
	// serial packet link to host
	input  wire logic        LINK_SCK,
	input  wire logic        LINK_SEL_N,
	output logic             LINK_SDO,
	output logic             PKT_READY,
	// long address: word index of first message word
	output logic      [6:0]  FIRST_MSG_WORD,
	output logic             FIRST_MSG_VALID,
	// interrupt
	output logic             IRQ
);

	// ==========================================================
	// helpers
	function automatic logic [2:0] type_code(input vpf_kind_e k);
		logic [2:0] c;
		c = VPF_V_SECURE;
		unique case (k)
			VPF_K_SECURE:   c = VPF_V_SECURE;   // see R10
			VPF_K_ALPHA:    c = VPF_V_ALPHA;    // see R10
			VPF_K_HEX:      c = VPF_V_HEX;      // see R10
			VPF_K_NUM_STD:  c = VPF_V_NUM_STD;  // see R14
			VPF_K_NUM_SPEC: c = VPF_V_NUM_SPEC; // see R14
			VPF_K_NUM_NUMB: c = VPF_V_NUM_NUMB; // see R14
			default:        c = VPF_V_SECURE;
		endcase
		return c;
	endfunction

	function automatic logic is_numeric(input vpf_kind_e k);
		return (k == VPF_K_NUM_STD) || (k == VPF_K_NUM_SPEC) || (k == VPF_K_NUM_NUMB);
	endfunction

	function automatic logic in_range(input logic [6:0] v, input logic [6:0] lo, input logic [6:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction

	// ==========================================================
	// link pin synchroniser
	logic [1:0] pin_level;
	logic [1:0] pin_rise;
	logic [1:0] pin_fall;

	// select idles high, link clock idles low
	vpf_sync #(
		.WIDTH      (2),
		.IDLE_LEVEL (2'h2)
	) u_sync (
		.clk      (CLOCK),
		.rst      (SYS_RST),
		.async_in ({LINK_SEL_N, LINK_SCK}),
		.level    (pin_level),
		.rise     (pin_rise),
		.fall     (pin_fall)
	);

	logic sel_active;
	logic sel_start;
	logic sel_end;
	logic sck_rise;
	logic sck_fall;

	assign sel_active = ~pin_level[1];
	assign sel_start  = pin_fall[1];
	assign sel_end    = pin_rise[1];
	assign sck_rise   = pin_rise[0];
	assign sck_fall   = pin_fall[0];

	// ==========================================================
	// field checks and packing
	logic [1:0]             ctrl_q;
	logic                   vec_err;
	logic                   vec_numeric;
	logic                   vec_bad_range;
	logic [2:0]             num_len;
	logic [VPF_PKT_BITS-1:0] pkt_d;

	assign vec_numeric = is_numeric(VEC_IN.kind);
	assign num_len     = 3'(VEC_IN.word_count - 7'h01); // see R5

	always_comb begin
		vec_bad_range = !in_range(VEC_IN.word_index, VPF_WI_MIN, VPF_WI_MAX)      // see R1
			|| !in_range(VEC_IN.start_word, VPF_START_MIN, VPF_START_MAX);    // see R7 R12
		if (vec_numeric) begin
			vec_bad_range = vec_bad_range || !in_range(VEC_IN.word_count, VPF_LEN_MIN, VPF_NUM_LEN_MAX);
		end else begin
			vec_bad_range = vec_bad_range || !in_range(VEC_IN.word_count, VPF_LEN_MIN, VPF_LEN_MAX); // see R11
		end
	end

	// see R2
	assign vec_err = VEC_IN.multi_err || VEC_IN.check_fail || VEC_IN.value_bad || vec_bad_range;

	// unused bits are driven as zero
	always_comb begin
		if (vec_numeric) begin
			pkt_d = {1'b0, VEC_IN.word_index,                      // see R1
				vec_err, VEC_IN.phase, 2'b00, type_code(VEC_IN.kind), // see R2 R3 R8
				2'b00, VEC_IN.check_bits, num_len,                   // see R4 R5
				VEC_IN.start_word};                                  // see R6 R7
		end else begin
			pkt_d = {1'b0, VEC_IN.word_index,                      // see R1
				vec_err, VEC_IN.phase, 2'b00, type_code(VEC_IN.kind), // see R3 R9
				2'b00, VEC_IN.word_count,                            // see R9 R11
				VEC_IN.start_word};                                  // see R12 R13
		end
	end

	// ==========================================================
	// packet holding register
	logic                    hold_q;
	logic [VPF_PKT_BITS-1:0] hold_pkt_q;
	logic                    vec_take;
	logic                    vec_drop_err;
	logic                    pkt_done;
	logic                    pkt_abort;
	logic                    vec_overrun;

	assign vec_drop_err = ctrl_q[VPF_CTRL_DROP_ERR] && vec_err;
	assign vec_take     = VEC_VALID && ctrl_q[VPF_CTRL_ENABLE] && !hold_q && !vec_drop_err; // see R15
	assign vec_overrun  = VEC_VALID && ctrl_q[VPF_CTRL_ENABLE] && hold_q;

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			hold_q     <= 1'b0;
			hold_pkt_q <= '0;
		end else begin
			if (vec_take) begin
				hold_q     <= 1'b1;
				hold_pkt_q <= pkt_d; // see R15
			end else if (pkt_done) begin
				hold_q     <= 1'b0;
			end
		end
	end

	// long address: first message word follows the vector
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			FIRST_MSG_WORD  <= 7'h00;
			FIRST_MSG_VALID <= 1'b0;
		end else begin
			FIRST_MSG_VALID <= 1'b0;
			if (vec_take && VEC_IN.long_addr && !vec_err) begin
				FIRST_MSG_WORD  <= 7'(VEC_IN.word_index + 7'h01); // see R6 R13
				FIRST_MSG_VALID <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			VEC_READY <= 1'b0;
			PKT_READY <= 1'b0;
		end else begin
			VEC_READY <= ctrl_q[VPF_CTRL_ENABLE] && !hold_q && !vec_take;
			PKT_READY <= (hold_q || vec_take) && !pkt_done;
		end
	end

	// ==========================================================
	// serial shifter, msb first, changes on falling link clock
	typedef enum logic [1:0] {
		VPF_S_IDLE,
		VPF_S_SHIFT,
		VPF_S_WAIT_END
	} vpf_state_e;

	vpf_state_e              state_q;
	logic [VPF_PKT_BITS-1:0] shift_q;
	logic [5:0]              bit_cnt_q;

	assign pkt_done  = (state_q != VPF_S_IDLE) && sel_end && (bit_cnt_q == VPF_PKT_BITS_CNT);
	assign pkt_abort = (state_q != VPF_S_IDLE) && sel_end && (bit_cnt_q != VPF_PKT_BITS_CNT);

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_q   <= VPF_S_IDLE;
			shift_q   <= '0;
			bit_cnt_q <= 6'h00;
		end else begin
			unique case (state_q)
				VPF_S_IDLE: begin
					if (sel_start && hold_q) begin
						shift_q   <= hold_pkt_q; // see R15
						bit_cnt_q <= 6'h00;
						state_q   <= VPF_S_SHIFT;
					end
				end
				VPF_S_SHIFT: begin
					if (sel_end) begin
						state_q <= VPF_S_IDLE;
					end else begin
						if (sck_rise) begin
							bit_cnt_q <= 6'(bit_cnt_q + 6'h01);
							if (bit_cnt_q == 6'(VPF_PKT_BITS_CNT - 6'h01)) begin
								state_q <= VPF_S_WAIT_END;
							end
						end
						if (sck_fall && bit_cnt_q != 6'h00) begin
							shift_q <= {shift_q[VPF_PKT_BITS-2:0], 1'b0};
						end
					end
				end
				VPF_S_WAIT_END: begin
					if (sel_end || !sel_active) begin
						state_q <= VPF_S_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			LINK_SDO <= 1'b0;
		end else begin
			LINK_SDO <= (state_q != VPF_S_IDLE) ? shift_q[VPF_PKT_BITS-1] : 1'b0;
		end
	end

	// ==========================================================
	// interrupts and registers
	logic [VPF_IRQ_W-1:0] irq_stat_q;
	logic [VPF_IRQ_W-1:0] irq_mask_q;
	logic [VPF_IRQ_W-1:0] irq_set;
	logic [VPF_IRQ_W-1:0] irq_clr;
	logic [15:0]          pkt_cnt_q;
	logic [VPF_PKT_BITS-1:0] last_pkt_q;

	always_comb begin
		irq_set                  = '0;
		irq_set[VPF_IRQ_SENT]    = pkt_done;
		irq_set[VPF_IRQ_OVERRUN] = vec_overrun;
		irq_set[VPF_IRQ_ERRVEC]  = VEC_VALID && ctrl_q[VPF_CTRL_ENABLE] && vec_err;
		irq_set[VPF_IRQ_ABORT]   = pkt_abort;
	end

	assign irq_clr = (REG_WR && REG_ADDR == VPF_ADDR_IRQ_STAT) ? REG_WDATA[VPF_IRQ_W-1:0] : '0;

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_stat_q <= VPF_IRQ_RESET;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ctrl_q     <= VPF_CTRL_RESET;
			irq_mask_q <= VPF_IRQ_RESET;
		end else if (REG_WR) begin
			if (REG_ADDR == VPF_ADDR_CTRL) begin
				ctrl_q <= REG_WDATA[1:0];
			end
			if (REG_ADDR == VPF_ADDR_IRQ_MASK) begin
				irq_mask_q <= REG_WDATA[VPF_IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pkt_cnt_q  <= 16'h0000;
			last_pkt_q <= '0;
		end else begin
			if (pkt_done) begin
				pkt_cnt_q  <= 16'(pkt_cnt_q + 16'h0001);
				last_pkt_q <= hold_pkt_q;
			end
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			REG_RDATA <= 32'h0000_0000;
		end else begin
			REG_RDATA <= 32'h0000_0000;
			if (REG_RD) begin
				unique case (REG_ADDR)
					VPF_ADDR_CTRL:     REG_RDATA <= {30'h0, ctrl_q};
					VPF_ADDR_IRQ_STAT: REG_RDATA <= {28'h0, irq_stat_q};
					VPF_ADDR_IRQ_MASK: REG_RDATA <= {28'h0, irq_mask_q};
					VPF_ADDR_LAST_PKT: REG_RDATA <= last_pkt_q;
					VPF_ADDR_PKT_CNT:  REG_RDATA <= {16'h0, pkt_cnt_q};
					VPF_ADDR_STATE:    REG_RDATA <= {24'h0, bit_cnt_q, hold_q, sel_active};
					default:           REG_RDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// >>> logic/vpf_pkg.sv
// vector packet formatter: shared constants, types and codes
// assumes a decoder on CLOCK that presents one decoded vector word per pulse
//
// Summary of operation
// R1: word index in byte 3, top bit zero
// R2: error flag from errors, check fail, invalid
// R3: phase a..d coded zero to three
// R4: numeric packets carry four leading check bits
// R5: numeric length is word count minus one
// R6: long numeric start points at second word
// R7: numeric start word is seven bits, 3..87
// R8: unused bits carry no value, host ignores
// R9: other types: type, seven-bit length, start
// R10: secure 000, alphanumeric 101, hex 110
// R11: other types length 1..85 words
// R12: other types start word 3..87
// R13: long address: first message after vector
// R14: numeric 011, special 100, numbered 111
// R15: one whole packet per vector, sent first
package vpf_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] VPF_ADDR_CTRL     = 8'h00;
	localparam logic [7:0] VPF_ADDR_IRQ_STAT = 8'h04;
	localparam logic [7:0] VPF_ADDR_IRQ_MASK = 8'h08;
	localparam logic [7:0] VPF_ADDR_LAST_PKT = 8'h0C;
	localparam logic [7:0] VPF_ADDR_PKT_CNT  = 8'h10;
	localparam logic [7:0] VPF_ADDR_STATE    = 8'h14;

	// control bits
	localparam int         VPF_CTRL_ENABLE   = 0;
	localparam int         VPF_CTRL_DROP_ERR = 1;
	localparam logic [1:0] VPF_CTRL_RESET    = 2'h1;

	// interrupt status / mask bits
	localparam int         VPF_IRQ_W        = 4;
	localparam int         VPF_IRQ_SENT     = 0;
	localparam int         VPF_IRQ_OVERRUN  = 1;
	localparam int         VPF_IRQ_ERRVEC   = 2;
	localparam int         VPF_IRQ_ABORT    = 3;
	localparam logic [3:0] VPF_IRQ_RESET    = 4'h0;

	// ==========================================================
	// packet geometry and value ranges
	localparam int         VPF_PKT_BITS     = 32;
	localparam logic [5:0] VPF_PKT_BITS_CNT = 6'h20;
	localparam logic [6:0] VPF_WI_MIN       = 7'h02;
	localparam logic [6:0] VPF_WI_MAX       = 7'h57;
	localparam logic [6:0] VPF_START_MIN    = 7'h03;
	localparam logic [6:0] VPF_START_MAX    = 7'h57;
	localparam logic [6:0] VPF_LEN_MIN      = 7'h01;
	localparam logic [6:0] VPF_LEN_MAX      = 7'h55;
	localparam logic [6:0] VPF_NUM_LEN_MAX  = 7'h08;

	// vector type codes
	localparam logic [2:0] VPF_V_SECURE     = 3'h0;
	localparam logic [2:0] VPF_V_NUM_STD    = 3'h3;
	localparam logic [2:0] VPF_V_NUM_SPEC   = 3'h4;
	localparam logic [2:0] VPF_V_ALPHA      = 3'h5;
	localparam logic [2:0] VPF_V_HEX        = 3'h6;
	localparam logic [2:0] VPF_V_NUM_NUMB   = 3'h7;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		VPF_K_SECURE,
		VPF_K_ALPHA,
		VPF_K_HEX,
		VPF_K_NUM_STD,
		VPF_K_NUM_SPEC,
		VPF_K_NUM_NUMB
	} vpf_kind_e;

	typedef enum logic [1:0] {
		VPF_PH_A,
		VPF_PH_B,
		VPF_PH_C,
		VPF_PH_D
	} vpf_phase_e;

	// one decoded vector word from the decoder
	typedef struct packed {
		logic [6:0] word_index;
		vpf_phase_e phase;
		vpf_kind_e  kind;
		logic       long_addr;
		logic       multi_err;
		logic       check_fail;
		logic       value_bad;
		logic [3:0] check_bits;
		logic [6:0] word_count;
		logic [6:0] start_word;
	} vpf_vec_s;

	// register bus request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} vpf_bus_s;

endpackage

// >>> logic/vpf_sync.sv
// vector packet formatter: two-flop synchroniser with edge detection
// assumes asynchronous inputs slower than CLOCK by several cycles
`timescale 1ns/1ps
`default_nettype none

module vpf_sync #(
	parameter int               WIDTH      = 2,
	parameter logic [WIDTH-1:0] IDLE_LEVEL = '0
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// asynchronous inputs
	input  wire logic [WIDTH-1:0] async_in,
	// synchronised level and edges
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] prev_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// start at the pins' idle levels, so no false edge follows reset
			meta_q <= IDLE_LEVEL;
			sync_q <= IDLE_LEVEL;
			prev_q <= IDLE_LEVEL;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~prev_q;
	assign fall  = ~sync_q & prev_q;

endmodule

`default_nettype wire

// >>> verification/vpf_props.sv
// checker: timing relations on the formatter's top-level ports
// assumes bound into vpf_top, drop_err used only with flagged error vectors
`timescale 1ns/1ps
`default_nettype none

module vpf_props
	import vpf_pkg::*;
(
	// clock and reset
	input wire logic        CLOCK,
	input wire logic        SYS_RST,
	// vector side
	input wire logic        VEC_VALID,
	input wire vpf_vec_s    VEC_IN,
	input wire logic        VEC_READY,
	input wire logic        PKT_READY,
	input wire logic [6:0]  FIRST_MSG_WORD,
	input wire logic        FIRST_MSG_VALID,
	// register and link side
	input wire logic        REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic        LINK_SEL_N,
	input wire logic        LINK_SDO,
	input wire logic        IRQ
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);

	// ==========================================================
	// assertions
	a_pkt_taken: assert property (VEC_VALID && VEC_READY && !VEC_IN.multi_err && !VEC_IN.check_fail && !VEC_IN.value_bad |=> PKT_READY)
		else $error("vector not taken");
	a_one_held: assert property (PKT_READY |-> !VEC_READY)
		else $error("ready while packet held");
	a_pkt_release: assert property ($fell(PKT_READY) |-> LINK_SEL_N && $past(LINK_SEL_N, 2))
		else $error("packet dropped while selected");
	a_sdo_msb: assert property ($fell(LINK_SEL_N) |-> !LINK_SDO [*8])
		else $error("first bit not zero");
	a_sdo_idle: assert property (!PKT_READY && !$past(PKT_READY) |-> !LINK_SDO)
		else $error("data line busy when idle");
	a_first_word: assert property (FIRST_MSG_VALID |-> $past(VEC_VALID) && $past(VEC_IN.long_addr)
		&& FIRST_MSG_WORD == $past(VEC_IN.word_index) + 7'h01)
		else $error("first message word wrong");
	a_first_pulse: assert property (FIRST_MSG_VALID |=> !FIRST_MSG_VALID)
		else $error("first word pulse too long");
	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0000_0000)
		else $error("read data outside its cycle");

	c_pkt: cover property ($rose(PKT_READY));
	c_long: cover property (FIRST_MSG_VALID);
	c_irq: cover property ($rose(IRQ));
endmodule

bind vpf_top vpf_props u_props (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .VEC_VALID(VEC_VALID),
	.VEC_IN(VEC_IN), .VEC_READY(VEC_READY), .PKT_READY(PKT_READY), .FIRST_MSG_WORD(FIRST_MSG_WORD),
	.FIRST_MSG_VALID(FIRST_MSG_VALID), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.LINK_SEL_N(LINK_SEL_N), .LINK_SDO(LINK_SDO), .IRQ(IRQ));
`default_nettype wire

// >>> verification/vpf_host_model.sv
// host model: selects, clocks a packet out msb first, returns the word
// assumes the link clock of 125 ns, idle low, free of the system clock
`timescale 1ns/1ps
`default_nettype none

module vpf_host_model (
	// request from bench
	input wire logic        go,
	input wire logic [5:0]  pulses,
	// link pins
	input wire logic        sdo,
	output logic            sck,
	output logic            sel_n,
	// result
	output logic [31:0]     word,
	output logic            done
);
	initial begin
		sck = 1'b0;
		sel_n = 1'b1;
		word = 32'h0000_0000;
		done = 1'b0;
	end

	// short pulse counts break the frame on purpose
	always @(posedge go) begin
		done = 1'b0;
		word = 32'h0000_0000;
		sel_n = 1'b0;
		#62.5;
		repeat (pulses) begin
			word = {word[30:0], sdo};
			sck = 1'b1;
			#62.5;
			sck = 1'b0;
			#62.5;
		end
		sel_n = 1'b1;
		#40;
		done = 1'b1;
	end
endmodule
`default_nettype wire

// >>> verification/vector_packet_formatter_test.sv
// bench: packet formats, link reads, registers and interrupt
// assumes vpf_top with its bound checker and the host link model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module vector_packet_formatter_test
	import vpf_pkg::*;
;
	localparam logic [31:0] MASK = 32'hFFE7_3FFF;
	localparam logic [2:0]  VC [6] = '{VPF_V_SECURE, VPF_V_ALPHA, VPF_V_HEX,
		VPF_V_NUM_STD, VPF_V_NUM_SPEC, VPF_V_NUM_NUMB};
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic        vec_valid = 1'b0;
	vpf_vec_s    vec_in = '0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        go = 1'b0;
	logic [5:0]  pulses = 6'h20;
	wire         sck, sel_n, sdo, hdone, vec_ready, pkt_ready, fm_valid, irq;
	wire [31:0]  hword, reg_rdata;
	wire [6:0]   fm_word;
	int          errors = 0;
	int          checked = 0;
	int          cyc = 0;

	vpf_top u_dut (.CLOCK(clock), .SYS_RST(sys_rst), .VEC_VALID(vec_valid), .VEC_IN(vec_in),
		.VEC_READY(vec_ready), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .LINK_SCK(sck), .LINK_SEL_N(sel_n),
		.LINK_SDO(sdo), .PKT_READY(pkt_ready), .FIRST_MSG_WORD(fm_word),
		.FIRST_MSG_VALID(fm_valid), .IRQ(irq));
	vpf_host_model u_host (.go(go), .pulses(pulses), .sdo(sdo), .sck(sck), .sel_n(sel_n),
		.word(hword), .done(hdone));

	always #2 clock = ~clock;

	// ==========================================================
	// helpers
	function automatic logic [31:0] expv(input vpf_vec_s v);
		logic num;
		logic e;
		num = v.kind inside {VPF_K_NUM_STD, VPF_K_NUM_SPEC, VPF_K_NUM_NUMB};
		e = v.multi_err | v.check_fail | v.value_bad | (v.word_index < 7'h02) | (v.word_index > 7'h57)
			| (v.start_word < 7'h03) | (v.start_word > 7'h57) | (v.word_count < 7'h01)
			| (v.word_count > (num ? 7'h08 : 7'h55));
		expv = {1'b0, v.word_index, e, v.phase, 2'b00, VC[v.kind], 2'b00,
			num ? {v.check_bits, v.word_count[2:0] - 3'h1} : v.word_count, v.start_word};
	endfunction

	function automatic vpf_vec_s mk(input int k, input logic [6:0] wi, n, s);
		mk = '0;
		mk.kind = vpf_kind_e'(k);
		mk.phase = vpf_phase_e'(k % 4);
		mk.word_index = wi;
		mk.check_bits = 4'h9;
		mk.word_count = n;
		mk.start_word = s;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		`CHK(reg_rdata, e)
	endtask

	task automatic send(input vpf_vec_s v);
		@(posedge clock);
		vec_valid <= 1'b1;
		vec_in <= v;
		@(posedge clock);
		vec_valid <= 1'b0;
	endtask

	task automatic hread(input logic [5:0] n, output logic [31:0] w);
		int i;
		@(posedge clock);
		go <= 1'b1;
		pulses <= n;
		@(posedge clock);
		go <= 1'b0;
		i = 0;
		while (hdone !== 1'b1 && i < 3000) begin
			@(posedge clock);
			i++;
		end
		if (hdone !== 1'b1) begin
			errors++;
		end
		w = hword;
	endtask

	task automatic take(input vpf_vec_s v);
		logic [31:0] w;
		@(negedge clock);
		`CHK(pkt_ready, 1'b1)
		hread(6'h20, w);
		`CHK(w & MASK, expv(v) & MASK)
		`CHK(pkt_ready, 1'b0)
		`CHK(vec_ready, 1'b1)
	endtask

	// ==========================================================
	// scenarios
	task automatic t_regs();
		rd(VPF_ADDR_CTRL, 32'h0000_0001);
		rd(VPF_ADDR_IRQ_STAT, 32'h0000_0000);
		rd(VPF_ADDR_IRQ_MASK, 32'h0000_0000);
		wr(8'h3C, 32'hFFFF_FFFF);
		rd(8'h3C, 32'h0000_0000);
	endtask

	task automatic t_kinds();
		for (int k = 0; k < 6; k++) begin
			send(mk(k, 7'(2 + 17 * k), k[0] ? (k > 2 ? 7'h08 : 7'h55) : 7'h01, k[0] ? 7'h57 : 7'h03));
			take(mk(k, 7'(2 + 17 * k), k[0] ? (k > 2 ? 7'h08 : 7'h55) : 7'h01, k[0] ? 7'h57 : 7'h03));
		end
	endtask

	task automatic t_errs();
		vpf_vec_s v;
		for (int j = 0; j < 5; j++) begin
			v = mk(3, (j == 3) ? 7'h01 : 7'h28, (j == 4) ? 7'h09 : 7'h02, 7'h0A);
			{v.multi_err, v.check_fail, v.value_bad} = (j < 3) ? 3'(4 >> j) : 3'h0;
			send(v);
			take(v);
		end
	endtask

	task automatic t_long();
		vpf_vec_s v;
		v = mk(1, 7'h0A, 7'h05, 7'h0C);
		v.long_addr = 1'b1;
		send(v);
		@(negedge clock);
		`CHK(fm_valid, 1'b1)
		`CHK(fm_word, 7'h0B)
		take(v);
	endtask

	task automatic t_irq();
		logic [31:0] w;
		vpf_vec_s v;
		v = mk(2, 7'h30, 7'h04, 7'h31);
		rd(VPF_ADDR_IRQ_STAT, 32'h0000_0005);
		`CHK(irq, 1'b0)
		wr(VPF_ADDR_IRQ_MASK, 32'h0000_0001);
		repeat (2) @(negedge clock);
		`CHK(irq, 1'b1)
		wr(VPF_ADDR_IRQ_STAT, 32'h0000_0005);
		rd(VPF_ADDR_IRQ_STAT, 32'h0000_0000);
		`CHK(irq, 1'b0)
		wr(VPF_ADDR_IRQ_MASK, 32'h0000_0008);
		send(v);
		send(mk(0, 7'h05, 7'h01, 7'h06));
		hread(6'h0A, w);
		rd(VPF_ADDR_IRQ_STAT, 32'h0000_000A);
		`CHK(irq, 1'b1)
		take(v);
		rd(VPF_ADDR_IRQ_STAT, 32'h0000_000B);
		rd(VPF_ADDR_LAST_PKT, expv(v));
		wr(VPF_ADDR_PKT_CNT, 32'h0000_0000);
		rd(VPF_ADDR_PKT_CNT, 32'h0000_000D);
		wr(VPF_ADDR_IRQ_STAT, 32'h0000_000F);
	endtask

	task automatic t_off();
		logic [31:0] w;
		vpf_vec_s v;
		v = mk(3, 7'h10, 7'h01, 7'h11);
		v.multi_err = 1'b1;
		wr(VPF_ADDR_CTRL, 32'h0000_0003);
		send(v);
		@(negedge clock);
		`CHK(pkt_ready, 1'b0)
		rd(VPF_ADDR_IRQ_STAT, 32'h0000_0004);
		wr(VPF_ADDR_CTRL, 32'h0000_0000);
		repeat (3) @(posedge clock);
		send(mk(3, 7'h10, 7'h01, 7'h11));
		repeat (3) @(negedge clock);
		`CHK(pkt_ready, 1'b0)
		`CHK(vec_ready, 1'b0)
		hread(6'h20, w);
		`CHK(w, 32'h0000_0000)
		wr(VPF_ADDR_CTRL, 32'h0000_0001);
	endtask

	task automatic conclude();
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			conclude();
		end
	end

	initial begin
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		t_regs();
		t_kinds();
		t_errs();
		t_long();
		t_irq();
		t_off();
		conclude();
	end
endmodule
`default_nettype wire
